// ### core/acs_pkg.sv
// How it works
// RULE_01 - sixteen-bit add, subtract, shift, logic operations
// RULE_02 - arithmetic is two's complement by default
// RULE_03 - each operation touches only its flags
// RULE_04 - subtract: carry flags mean inverted borrow
// RULE_05 - nibble carry from bit 3 or 7
// RULE_06 - byte or word width per instruction
// RULE_07 - operand from working registers or memory
// RULE_08 - result goes to registers or memory
// RULE_09 - hardware multiplier plus sixteen-bit divisor divide
// RULE_10 - multiplier is 17 by 17, extended operands
// RULE_11 - signed, unsigned and mixed-sign register products
// RULE_12 - operand times unsigned five-bit literal
// RULE_13 - byte by byte unsigned product
// RULE_14 - priority level is upper bit over field
// RULE_15 - upper bit set maps levels 8 to 15
// RULE_16 - upper bit set above 7; software clears only
// RULE_17 - upper bit blocks all user interrupts
// RULE_18 - window enable maps program space into data
// RULE_19 - unimplemented bits ignore writes, read zero
// RULE_20 - carry from msb, negative msb, signed overflow
// RULE_21 - zero flag tracks result; repeat flag read-only
// RULE_22 - priority field locked while nesting disabled
package acs_pkg;

   // ************************************************
   // register map
   // ************************************************
   localparam logic [3:0]  FLAG_WORD_OFFSET  = 4'h0;
   localparam logic [3:0]  CORE_CTRL_OFFSET  = 4'h4;
   localparam logic [15:0] FLAG_WORD_RESET   = 16'h0000;
   localparam logic [15:0] CORE_CTRL_RESET   = 16'h0000;
   localparam logic [15:0] FLAG_IMPL_MASK    = 16'h01FF;
   localparam logic [15:0] FLAG_SW_MASK      = 16'h01EF;
   localparam logic [15:0] FLAG_PRIO_MASK    = 16'h00E0;
   localparam logic [15:0] FLAG_ARITH_MASK   = 16'h010F;
   localparam logic [15:0] FLAG_LOGIC_MASK   = 16'h000A;
   localparam logic [15:0] FLAG_SHIFT_MASK   = 16'h000B;
   localparam int          FLAG_C_BIT        = 0;
   localparam int          FLAG_Z_BIT        = 1;
   localparam int          FLAG_OV_BIT       = 2;
   localparam int          FLAG_N_BIT        = 3;
   localparam int          FLAG_RA_BIT       = 4;
   localparam int          FLAG_PRIO_LSB     = 5;
   localparam int          FLAG_DC_BIT       = 8;
   localparam int          CTRL_PSV_BIT      = 2;
   localparam int          CTRL_UPPER_BIT    = 3;
   localparam logic [4:0]  DIV_LAST_STEP     = 5'h0F;
   localparam logic [4:0]  DIV_COUNT_RESET   = 5'h00;

   // ************************************************
   // types
   // ************************************************
   typedef enum logic [3:0] {
      ACS_OP_ADD    = 4'h0,
      ACS_OP_SUB    = 4'h1,
      ACS_OP_AND    = 4'h2,
      ACS_OP_IOR    = 4'h3,
      ACS_OP_XOR    = 4'h4,
      ACS_OP_SHL    = 4'h5,
      ACS_OP_LSR    = 4'h6,
      ACS_OP_ASR    = 4'h7,
      ACS_OP_MUL_SS = 4'h8,
      ACS_OP_MUL_UU = 4'h9,
      ACS_OP_MUL_US = 4'hA,
      ACS_OP_MUL_SU = 4'hB,
      ACS_OP_MUL_SL = 4'hC,
      ACS_OP_MUL_UL = 4'hD,
      ACS_OP_MUL_BB = 4'hE,
      ACS_OP_DIV    = 4'hF
   } acs_opcode_t;

   typedef enum logic [0:0] {
      DIV_IDLE = 1'b0,
      DIV_RUN  = 1'b1
   } acs_div_state_t;

   typedef struct packed {
      acs_opcode_t opcode;
      logic        byteMode;
      logic        srcMem;
      logic        dstMem;
      logic [15:0] opA;
      logic [15:0] wregData;
      logic [15:0] memData;
      logic [4:0]  lit5;
   } acs_op_req_t;

endpackage : acs_pkg

// ### core/acs_alu_core.sv
`timescale 1ns/10ps
`default_nettype none
module acs_alu_core (
   input  wire logic               clk,
   input  wire logic               resetn,
   input  wire logic               opValid,
   input  wire acs_pkg::acs_op_req_t opReq,
   input  wire logic               prioLoad,
   input  wire logic [3:0]         prioLevel,
   input  wire logic               repeatLoopBusy,
   input  wire logic               nestingDisable,
   input  wire logic               cyc_i,
   input  wire logic               stb_i,
   input  wire logic               we_i,
   input  wire logic [3:0]         adr_i,
   input  wire logic [3:0]         sel_i,
   input  wire logic [31:0]        dat_i,
   output logic                    ack_o,
   output logic [31:0]             dat_o,
   output logic                    aluBusy,
   output logic [31:0]             resultData,
   output logic                    resultWregWe,
   output logic                    resultMemWe,
   output logic [15:0]             aluFlagWord,
   output logic [3:0]              cpuPriorityLevel,
   output logic                    userIrqBlocked,
   output logic                    programSpaceWindowEnable
);

   // ************************************************
   // state
   // ************************************************
   logic [15:0]             flag_reg;
   logic [15:0]             flag_next;
   logic                    upper_reg;
   logic                    upper_next;
   logic                    psv_reg;
   logic                    ack_reg;
   logic [31:0]             rdat_reg;
   logic [31:0]             res_reg;
   logic                    wregWe_reg;
   logic                    memWe_reg;
   acs_pkg::acs_div_state_t divState_reg;
   logic [4:0]              divCnt_reg;
   logic [15:0]             divRem_reg;
   logic [15:0]             divQuo_reg;
   logic [15:0]             divSor_reg;
   logic                    divDst_reg;

   // ************************************************
   // operand path
   // ************************************************
   logic        opTake;
   logic        isSub;
   logic        cin;
   logic [15:0] a;
   logic [15:0] b;
   logic [15:0] bx;
   logic [4:0]  nibSum;
   logic [8:0]  loSum;
   logic [16:0] wSum;
   logic [7:0]  r8;
   logic [15:0] r16;
   logic [15:0] aluRes;
   logic [31:0] wideRes;
   logic        isWide;
   logic        carryOut;
   logic        nibCarry;
   logic        ovf;
   logic [15:0] aluMask;
   logic [15:0] aluFlags;
   logic [16:0] mulA;
   logic [16:0] mulB;
   logic [33:0] mulProd;
   logic [16:0] divShift;
   logic [17:0] divDiff;
   logic        divBorrow;

   assign opTake = opValid && !aluBusy;
   assign a      = opReq.opA;
   assign b      = opReq.srcMem ? opReq.memData : opReq.wregData; // RULE_07
   assign isSub  = (opReq.opcode == acs_pkg::ACS_OP_SUB);
   // subtract is add of the complement, so carries come out as inverted borrows
   assign bx     = isSub ? ~b : b; // RULE_04
   assign cin    = isSub;
   assign nibSum = {1'b0, a[3:0]} + {1'b0, bx[3:0]} + {4'h0, cin};
   assign loSum  = {1'b0, a[7:0]} + {1'b0, bx[7:0]} + {8'h00, cin};
   assign wSum   = {1'b0, a} + {1'b0, bx} + {16'h0000, cin}; // RULE_02

   // ************************************************
   // multiplier, 17 by 17 signed core
   // ************************************************
   always_comb
   begin
      mulA = {1'b0, a};
      mulB = {1'b0, b};
      case (opReq.opcode)
         acs_pkg::ACS_OP_MUL_SS:
         begin
            mulA = {a[15], a}; // RULE_10
            mulB = {b[15], b}; // RULE_11
         end
         acs_pkg::ACS_OP_MUL_US: mulB = {b[15], b}; // RULE_11
         acs_pkg::ACS_OP_MUL_SU: mulA = {a[15], a}; // RULE_11
         acs_pkg::ACS_OP_MUL_SL:
         begin
            mulA = {a[15], a};
            mulB = {12'h000, opReq.lit5}; // RULE_12
         end
         acs_pkg::ACS_OP_MUL_UL: mulB = {12'h000, opReq.lit5}; // RULE_12
         acs_pkg::ACS_OP_MUL_BB:
         begin
            mulA = {9'h000, a[7:0]}; // RULE_13
            mulB = {9'h000, b[7:0]};
         end
         default:
         begin
            mulA = {1'b0, a};
            mulB = {1'b0, b};
         end
      endcase
   end

   // one shared array serves every mode; extension picks the signedness
   assign mulProd = 34'($signed(mulA) * $signed(mulB)); // RULE_09

   // ************************************************
   // add, subtract, logic, shift
   // ************************************************
   always_comb
   begin
      r8       = 8'h00;
      r16      = 16'h0000;
      carryOut = 1'b0;
      nibCarry = 1'b0;
      ovf      = 1'b0;
      aluMask  = 16'h0000;
      isWide   = 1'b0;
      wideRes  = 32'h0000_0000;
      case (opReq.opcode)
         acs_pkg::ACS_OP_ADD, acs_pkg::ACS_OP_SUB:
         begin
            r8       = loSum[7:0];
            r16      = wSum[15:0];
            carryOut = opReq.byteMode ? loSum[8] : wSum[16]; // RULE_20
            nibCarry = opReq.byteMode ? nibSum[4] : loSum[8]; // RULE_05
            ovf      = opReq.byteMode ? ((a[7] == bx[7]) && (loSum[7] != a[7]))
                                      : ((a[15] == bx[15]) && (wSum[15] != a[15])); // RULE_20
            aluMask  = acs_pkg::FLAG_ARITH_MASK; // RULE_03
         end
         acs_pkg::ACS_OP_AND:
         begin
            r8      = a[7:0] & b[7:0];
            r16     = a & b;
            aluMask = acs_pkg::FLAG_LOGIC_MASK; // RULE_03
         end
         acs_pkg::ACS_OP_IOR:
         begin
            r8      = a[7:0] | b[7:0];
            r16     = a | b;
            aluMask = acs_pkg::FLAG_LOGIC_MASK;
         end
         acs_pkg::ACS_OP_XOR:
         begin
            r8      = a[7:0] ^ b[7:0];
            r16     = a ^ b;
            aluMask = acs_pkg::FLAG_LOGIC_MASK;
         end
         acs_pkg::ACS_OP_SHL:
         begin
            r8       = {a[6:0], 1'b0};
            r16      = {a[14:0], 1'b0};
            carryOut = opReq.byteMode ? a[7] : a[15];
            aluMask  = acs_pkg::FLAG_SHIFT_MASK;
         end
         acs_pkg::ACS_OP_LSR:
         begin
            r8       = {1'b0, a[7:1]};
            r16      = {1'b0, a[15:1]};
            carryOut = a[0];
            aluMask  = acs_pkg::FLAG_SHIFT_MASK;
         end
         acs_pkg::ACS_OP_ASR:
         begin
            r8       = {a[7], a[7:1]};
            r16      = {a[15], a[15:1]};
            carryOut = a[0];
            aluMask  = acs_pkg::FLAG_SHIFT_MASK;
         end
         acs_pkg::ACS_OP_DIV:
         begin
            isWide = 1'b1;
         end
         default:
         begin
            // products leave every flag alone
            isWide  = 1'b1;
            wideRes = mulProd[31:0];
         end
      endcase
   end

   // byte operations keep the upper half of the first operand
   assign aluRes = opReq.byteMode ? {a[15:8], r8} : r16; // RULE_06

   always_comb
   begin
      aluFlags                        = 16'h0000;
      aluFlags[acs_pkg::FLAG_C_BIT]   = carryOut;
      aluFlags[acs_pkg::FLAG_OV_BIT]  = ovf;
      aluFlags[acs_pkg::FLAG_DC_BIT]  = nibCarry;
      aluFlags[acs_pkg::FLAG_N_BIT]   = opReq.byteMode ? aluRes[7] : aluRes[15]; // RULE_20
      aluFlags[acs_pkg::FLAG_Z_BIT]   = opReq.byteMode ? (aluRes[7:0] == 8'h00)
                                                       : (aluRes == 16'h0000); // RULE_21
   end

   // ************************************************
   // divider, one quotient bit per cycle
   // ************************************************
   assign divShift  = {divRem_reg, divQuo_reg[15]};
   assign divDiff   = {1'b0, divShift} - {2'b00, divSor_reg};
   assign divBorrow = divDiff[17];

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         divState_reg <= acs_pkg::DIV_IDLE;
         divCnt_reg   <= acs_pkg::DIV_COUNT_RESET;
         divRem_reg   <= 16'h0000;
         divQuo_reg   <= 16'h0000;
         divSor_reg   <= 16'h0000;
         divDst_reg   <= 1'b0;
      end
      else
      begin
         case (divState_reg)
            acs_pkg::DIV_IDLE:
            begin
               if (opTake && (opReq.opcode == acs_pkg::ACS_OP_DIV)) // RULE_09
               begin
                  divState_reg <= acs_pkg::DIV_RUN;
                  divCnt_reg   <= acs_pkg::DIV_COUNT_RESET;
                  divRem_reg   <= 16'h0000;
                  divQuo_reg   <= a;
                  divSor_reg   <= b;
                  divDst_reg   <= opReq.dstMem;
               end
            end
            acs_pkg::DIV_RUN:
            begin
               divRem_reg <= divBorrow ? divShift[15:0] : divDiff[15:0];
               divQuo_reg <= {divQuo_reg[14:0], ~divBorrow};
               divCnt_reg <= divCnt_reg + 5'h01;
               if (divCnt_reg == acs_pkg::DIV_LAST_STEP)
               begin
                  divState_reg <= acs_pkg::DIV_IDLE;
               end
            end
            default: divState_reg <= acs_pkg::DIV_IDLE;
         endcase
      end
   end

   // ************************************************
   // result and write strobes
   // ************************************************
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         res_reg    <= 32'h0000_0000;
         wregWe_reg <= 1'b0;
         memWe_reg  <= 1'b0;
         aluBusy    <= 1'b0;
      end
      else
      begin
         wregWe_reg <= 1'b0;
         memWe_reg  <= 1'b0;
         if ((divState_reg == acs_pkg::DIV_RUN) && (divCnt_reg == acs_pkg::DIV_LAST_STEP))
         begin
            // remainder high, quotient low
            res_reg    <= {(divBorrow ? divShift[15:0] : divDiff[15:0]),
                           divQuo_reg[14:0], ~divBorrow};
            wregWe_reg <= !divDst_reg;
            memWe_reg  <= divDst_reg;
            aluBusy    <= 1'b0;
         end
         else if (opTake && (opReq.opcode == acs_pkg::ACS_OP_DIV))
         begin
            aluBusy <= 1'b1;
         end
         else if (opTake)
         begin
            res_reg    <= isWide ? wideRes : {16'h0000, aluRes}; // RULE_01
            wregWe_reg <= !opReq.dstMem; // RULE_08
            memWe_reg  <= opReq.dstMem; // RULE_08
         end
      end
   end

   // ************************************************
   // status and control words
   // ************************************************
   logic        flagWrite;
   logic        ctrlWrite;
   logic [15:0] laneMask;
   logic [15:0] swMask;
   logic [15:0] flagSw;
   logic [15:0] flagAlu;

   assign flagWrite = cyc_i && stb_i && we_i && ack_reg && (adr_i == acs_pkg::FLAG_WORD_OFFSET);
   assign ctrlWrite = cyc_i && stb_i && we_i && ack_reg && (adr_i == acs_pkg::CORE_CTRL_OFFSET);
   assign laneMask  = {{8{sel_i[1]}}, {8{sel_i[0]}}};

   always_comb
   begin
      swMask = acs_pkg::FLAG_SW_MASK & laneMask; // RULE_19
      if (nestingDisable)
      begin
         swMask = swMask & ~acs_pkg::FLAG_PRIO_MASK; // RULE_22
      end
      if (!flagWrite)
      begin
         swMask = 16'h0000;
      end
      flagSw  = (flag_reg & ~swMask) | (dat_i[15:0] & swMask);
      // a flag update from the datapath beats a software write in the same cycle
      flagAlu = opTake ? ((flagSw & ~aluMask) | (aluFlags & aluMask)) : flagSw; // RULE_03
      flag_next = flagAlu;
      if (prioLoad)
      begin
         flag_next[acs_pkg::FLAG_PRIO_LSB +: 3] = prioLevel[2:0]; // RULE_14
      end
      flag_next[acs_pkg::FLAG_RA_BIT] = repeatLoopBusy; // RULE_21
      flag_next = flag_next & acs_pkg::FLAG_IMPL_MASK; // RULE_19
   end

   always_comb
   begin
      upper_next = upper_reg;
      if (ctrlWrite && sel_i[0] && !dat_i[acs_pkg::CTRL_UPPER_BIT])
      begin
         upper_next = 1'b0; // RULE_16
      end
      if (prioLoad)
      begin
         upper_next = prioLevel[3]; // RULE_16
      end
   end

   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         flag_reg  <= acs_pkg::FLAG_WORD_RESET;
         upper_reg <= acs_pkg::CORE_CTRL_RESET[acs_pkg::CTRL_UPPER_BIT];
         psv_reg   <= acs_pkg::CORE_CTRL_RESET[acs_pkg::CTRL_PSV_BIT];
      end
      else
      begin
         flag_reg  <= flag_next;
         upper_reg <= upper_next;
         if (ctrlWrite && sel_i[0])
         begin
            psv_reg <= dat_i[acs_pkg::CTRL_PSV_BIT]; // RULE_18
         end
      end
   end

   // ************************************************
   // wishbone slave, one wait state
   // ************************************************
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         ack_reg  <= 1'b0;
         rdat_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg <= cyc_i && stb_i && !ack_reg;
         if (adr_i == acs_pkg::FLAG_WORD_OFFSET)
         begin
            rdat_reg <= {16'h0000, flag_reg};
         end
         else if (adr_i == acs_pkg::CORE_CTRL_OFFSET)
         begin
            rdat_reg <= {28'h000_0000, upper_reg, psv_reg, 2'b00}; // RULE_19
         end
         else
         begin
            rdat_reg <= 32'h0000_0000;
         end
      end
   end

   assign ack_o                    = ack_reg;
   assign dat_o                    = rdat_reg;
   assign resultData               = res_reg;
   assign resultWregWe             = wregWe_reg;
   assign resultMemWe              = memWe_reg;
   assign aluFlagWord              = flag_reg;
   assign cpuPriorityLevel         = {upper_reg, flag_reg[7:5]}; // RULE_15
   assign userIrqBlocked           = upper_reg; // RULE_17
   assign programSpaceWindowEnable = psv_reg; // RULE_18

   // ************************************************
   // checks
   // ************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   logic wordAdd;
   logic wordSub;
   assign wordAdd = opTake && (opReq.opcode == acs_pkg::ACS_OP_ADD) && !opReq.byteMode;
   assign wordSub = opTake && isSub && !opReq.byteMode;

   chk_add_word_result: assert property (wordAdd |=> resultData[15:0] == 16'($past(a) + $past(b)))
      else $error("word add result wrong"); // RULE_01
   chk_sub_carry_borrow: assert property (wordSub |=>
      aluFlagWord[acs_pkg::FLAG_C_BIT] == ($past(a) >= $past(b)))
      else $error("subtract carry is not inverted borrow"); // RULE_04
   chk_logic_keeps_flags: assert property (
      opTake && (opReq.opcode == acs_pkg::ACS_OP_AND) && !prioLoad && !flagWrite |=>
      aluFlagWord[8] == $past(flag_reg[8]) && aluFlagWord[2] == $past(flag_reg[2])
      && aluFlagWord[0] == $past(flag_reg[0]))
      else $error("logic op changed carry or overflow"); // RULE_03
   chk_byte_upper_kept: assert property (
      opTake && opReq.byteMode && !isWide |=> resultData[15:8] == $past(a[15:8]))
      else $error("byte op altered upper half"); // RULE_06
   chk_zero_flag_track: assert property (
      opTake && (opReq.opcode == acs_pkg::ACS_OP_XOR) && !opReq.byteMode |=>
      aluFlagWord[acs_pkg::FLAG_Z_BIT] == (resultData[15:0] == 16'h0000))
      else $error("zero flag disagrees with result"); // RULE_21
   chk_mul_signed_prod: assert property (
      opTake && (opReq.opcode == acs_pkg::ACS_OP_MUL_SS) |=>
      resultData == 32'($signed($past(a)) * $signed($past(b))))
      else $error("signed product wrong"); // RULE_11
   chk_div_latency: assert property (
      opTake && (opReq.opcode == acs_pkg::ACS_OP_DIV) |=>
      aluBusy [*8] ##1 aluBusy [*8] ##1 ((resultWregWe || resultMemWe) && !aluBusy))
      else $error("divide result not on the seventeenth cycle"); // RULE_09
   chk_upper_on_load: assert property (prioLoad && prioLevel[3] |=>
      userIrqBlocked && cpuPriorityLevel == $past(prioLevel))
      else $error("high priority load did not set upper bit"); // RULE_16
   chk_upper_no_sw_set: assert property (ctrlWrite && !upper_reg && !prioLoad |=> !userIrqBlocked)
      else $error("software set the upper priority bit"); // RULE_16
   chk_prio_field_lock: assert property (flagWrite && nestingDisable && !prioLoad |=>
      $stable(aluFlagWord[7:5]))
      else $error("priority field written while locked"); // RULE_22
   chk_unimpl_zero: assert property (ack_o |-> dat_o[31:9] == 23'h00_0000)
      else $error("unimplemented bits read nonzero"); // RULE_19
   chk_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   cov_divide: cover property (opTake && (opReq.opcode == acs_pkg::ACS_OP_DIV));
   cov_byte_mul: cover property (opTake && (opReq.opcode == acs_pkg::ACS_OP_MUL_BB));
   cov_sub_borrow: cover property (wordSub ##1 !aluFlagWord[acs_pkg::FLAG_C_BIT]);
   cov_upper_clear: cover property (upper_reg ##1 !upper_reg);

endmodule : acs_alu_core
`default_nettype wire

// ### verification/acs_decoder_model.sv
`timescale 1ns/10ps
`default_nettype none
// ********************************
// decoder and sequencer stand-in
// ********************************
module acs_decoder_model (
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic                 issue,
   input  wire acs_pkg::acs_op_req_t issueReq,
   input  wire logic                 aluBusy,
   output var  logic                 opValid,
   output var  acs_pkg::acs_op_req_t opReq
);
   // a request met by busy stays up; once taken the fields are scrambled
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         opValid <= 1'b0;
         opReq   <= '0;
      end
      else if (issue)
      begin
         opValid <= 1'b1;
         opReq   <= issueReq;
      end
      else if (opValid && !aluBusy)
      begin
         opValid <= 1'b0;
         opReq   <= ~opReq;
      end
   end
endmodule : acs_decoder_model
`default_nettype wire

// ### verification/acs_alu_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module acs_alu_core_tb;
   logic                 clk, resetn, issue, prioLoad, repeatLoopBusy, nestingDisable;
   logic                 cyc_i, stb_i, we_i, ack_o, opValid, aluBusy, wregWe, memWe;
   logic                 irqBlocked, psvEn;
   logic [3:0]           adr_i, sel_i, prioLevel, cpuPrio;
   logic [31:0]          dat_i, dat_o, resData, e;
   logic [15:0]          flagWord, q, f;
   acs_pkg::acs_op_req_t opReq, req, r;
   int                   miscompares, cmpCount, n, nb;

   acs_alu_core i_acs_alu_core (.clk(clk), .resetn(resetn), .opValid(opValid), .opReq(opReq),
      .prioLoad(prioLoad), .prioLevel(prioLevel), .repeatLoopBusy(repeatLoopBusy),
      .nestingDisable(nestingDisable), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
      .aluBusy(aluBusy), .resultData(resData), .resultWregWe(wregWe), .resultMemWe(memWe),
      .aluFlagWord(flagWord), .cpuPriorityLevel(cpuPrio), .userIrqBlocked(irqBlocked),
      .programSpaceWindowEnable(psvEn));
   acs_decoder_model i_acs_decoder_model (.clk(clk), .resetn(resetn), .issue(issue),
      .issueReq(req), .aluBusy(aluBusy), .opValid(opValid), .opReq(opReq));

   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp)
      begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", cmpCount, miscompares);
      if (miscompares == 0 && cmpCount > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict

   // ********************************
   // bus cycles and expectations
   // ********************************
   task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 16'h0000, d};
      repeat (20)
      begin
         @(posedge clk);
         if (ack_o === 1'b1)
            break;
      end
      // a request that is never answered counts against the run
      if (ack_o !== 1'b1)
         miscompares++;
      q = dat_o[15:0];
      {cyc_i, stb_i} <= 2'b00;
   endtask : bus

   task automatic rd(input logic [3:0] a, input logic [15:0] x);
      bus(1'b0, a, 16'h0000);
      chk(q, x);
   endtask : rd

   // opcode numbers follow the package encoding
   function automatic logic [31:0] calc(input acs_pkg::acs_op_req_t r, inout logic [15:0] f);
      logic [15:0] a, b, m, x;
      logic [16:0] s;
      logic [8:0]  h;
      logic [33:0] p;
      logic [3:0]  o;
      int          w;
      o = r.opcode;
      w = r.byteMode ? 8 : 16;
      m = r.byteMode ? 16'h00FF : 16'hFFFF;
      a = r.opA & m;
      b = (r.srcMem ? r.memData : r.wregData) & m;
      if (o == 4'h1)
         b = ~b & m;
      s = a + b + (o == 4'h1);
      h = (a & (m >> w / 2)) + (b & (m >> w / 2)) + (o == 4'h1);
      x = o == 4'h2 ? a & b : o == 4'h3 ? a | b : o == 4'h4 ? a ^ b : o == 4'h5 ? a << 1 :
          o == 4'h6 ? a >> 1 : o == 4'h7 ? (a >> 1) | (a & (16'h0001 << (w - 1))) : s[15:0];
      x = x & m;
      if (o < 4'h2)
         f = (f & ~acs_pkg::FLAG_ARITH_MASK) | {7'h00, h[w / 2], 4'h0, x[w - 1],
             a[w - 1] == b[w - 1] && x[w - 1] != a[w - 1], x == 16'h0000, s[w]};
      else if (o < 4'h8)
         f = (f & ~(o < 4'h5 ? acs_pkg::FLAG_LOGIC_MASK : acs_pkg::FLAG_SHIFT_MASK)) |
             {12'h000, x[w - 1], 1'b0, x == 16'h0000, o == 4'h5 ? a[w - 1] : o > 4'h5 && a[0]};
      if (o < 4'h8)
         return r.byteMode ? {16'h0000, r.opA[15:8], x[7:0]} : {16'h0000, x};
      if (o == 4'hF)
         return {a % b, a / b};
      if (o == 4'hC || o == 4'hD)
         b = {11'h000, r.lit5};
      if (o == 4'hE)
         {a, b} = {a & 16'h00FF, b & 16'h00FF};
      p = $signed({o inside {4'h8, 4'hB, 4'hC} && a[15], a}) *
          $signed({o inside {4'h8, 4'hA} && b[15], b});
      return p[31:0];
   endfunction : calc

   initial
   begin
      {resetn, issue, prioLoad, repeatLoopBusy, nestingDisable, cyc_i, stb_i, we_i} = '0;
      {adr_i, prioLevel, dat_i, req, miscompares, cmpCount} = '0;
      sel_i = 4'h3;
      void'($urandom(32'h8ba8));
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      rd(4'h0, 16'h0000);
      rd(4'h4, 16'h0000);
      rd(4'h8, 16'h0000);
      bus(1'b1, 4'h0, 16'hFFFF);
      rd(4'h0, 16'h01EF);
      chk(cpuPrio, 4'h7);
      bus(1'b1, 4'h4, 16'hFFFF);
      rd(4'h4, 16'h0004);
      chk({irqBlocked, psvEn}, 2'b01);
      nestingDisable <= 1'b1;
      bus(1'b1, 4'h0, 16'h0000);
      rd(4'h0, 16'h00E0);
      nestingDisable <= 1'b0;
      $display("test registers done");
      @(posedge clk);
      {prioLoad, prioLevel} <= 5'h1C;
      @(posedge clk);
      prioLoad <= 1'b0;
      @(negedge clk);
      chk({irqBlocked, cpuPrio}, 5'h1C);
      rd(4'h4, 16'h000C);
      bus(1'b1, 4'h4, 16'h0000);
      repeatLoopBusy <= 1'b1;
      @(negedge clk);
      chk({irqBlocked, cpuPrio}, 5'h04);
      bus(1'b1, 4'h0, 16'h0000);
      rd(4'h0, 16'h0010);
      repeatLoopBusy <= 1'b0;
      $display("test priority done");
      f = 16'h0000;
      for (int i = 0; i < 48; i++)
      begin
         r = 60'({$urandom, $urandom});
         if (i < 16)
            r.opcode = acs_pkg::acs_opcode_t'(4'(i));
         if (i == 16)
            r = '{acs_pkg::ACS_OP_ADD, 1'b0, 1'b0, 1'b1, 16'h7FFF, 16'h0001, 16'h0000, 5'h00};
         r.byteMode &= !r.opcode[3];
         r.wregData[0] |= r.opcode == acs_pkg::ACS_OP_DIV;
         r.memData[0] |= r.opcode == acs_pkg::ACS_OP_DIV;
         e = calc(r, f);
         @(posedge clk);
         {issue, req} <= {1'b1, r};
         @(posedge clk);
         issue <= 1'b0;
         n  = 0;
         nb = 0;
         while (n < 40 && wregWe !== 1'b1 && memWe !== 1'b1)
         begin
            @(negedge clk);
            n++;
            nb += (aluBusy === 1'b1);
         end
         chk(n, r.opcode == acs_pkg::ACS_OP_DIV ? 18 : 2);
         chk(nb, r.opcode == acs_pkg::ACS_OP_DIV ? 16 : 0);
         chk(resData, e);
         chk({memWe, wregWe}, r.dstMem ? 2'b10 : 2'b01);
         chk(flagWord, f);
      end
      $display("test datapath done");
      print_verdict();
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      miscompares++;
      print_verdict();
   end
endmodule : acs_alu_core_tb
`default_nettype wire
